// ### core/lock_reset_pkg.sv
// Package with opcodes, timing constants and carrier types for the lock and soft-reset interpreter.
package lock_reset_pkg;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7E;
  localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET_DEVICE = 8'h99;
  localparam int CLK_MHZ = 100;
  localparam int RECOVERY_US = 30;
  localparam int RECOVERY_CYCLES = RECOVERY_US * CLK_MHZ;
  localparam int POWERUP_WRITE_DELAY_MS = 5;
  localparam int SUPPLY_TO_SELECT_DELAY_US = 20;
  localparam logic [7:0] READ_PARAM_RESET = 8'h00;
  localparam logic [2:0] BIT_CNT_RESET = 3'h0;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic serial_in;
  } spi_pins_s;

  typedef struct packed {
    logic write_enable_latch;
    logic reset_armed;
    logic recovering;
  } status_s;
endpackage : lock_reset_pkg

// ### core/flash_global_lock_and_soft_reset.sv
// Serial command interpreter for global block lock/unlock and two-step software reset.
`timescale 1ns/1ps
module flash_global_lock_and_soft_reset
  import lock_reset_pkg::*;
#(
  parameter int NUM_BLOCKS = 16,
  parameter int RECOVERY_COUNT = RECOVERY_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire spi_pins_s spi_pins,
  input wire logic per_block_protect_select,
  input wire logic [NUM_BLOCKS-1:0] range_protect,
  input wire logic internal_busy,
  input wire logic suspend_in,
  output logic [NUM_BLOCKS-1:0] block_lock,
  output logic [NUM_BLOCKS-1:0] write_protect,
  output status_s status,
  output logic suspend_flag,
  output logic [7:0] read_parameter_bits,
  output logic abort_pulse
);
  // Counter width holds the full recovery count.
  localparam int CW = $clog2(RECOVERY_COUNT + 1);

  // Two-stage synchronisers for the pins; stage one is read only by stage two.
  // Select idles high, so both stages start deselected and no false frame end follows reset.
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  logic sck_d_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_s1_r <= 3'h4;
      pin_s2_r <= 3'h4;
      sck_d_r <= 1'b0;
    end else begin
      pin_s1_r <= {spi_pins.cs_n, spi_pins.sck, spi_pins.serial_in};
      pin_s2_r <= pin_s1_r;
      sck_d_r <= pin_s2_r[1];
    end
  end

  // Serial clock edges count only while select is low; edges outside a frame are dropped.
  logic cs_n_q;
  logic sck_rise;
  logic din_q;
  assign cs_n_q = pin_s2_r[2];
  assign sck_rise = pin_s2_r[1] & ~sck_d_r & ~cs_n_q;
  assign din_q = pin_s2_r[0];

  // Frame tracking: exact_r marks exactly eight bits so far, over_r marks any bit beyond them.
  logic cs_d_r;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [2:0] bit_cnt_r;
  logic [2:0] bit_cnt_nxt;
  logic exact_r;
  logic exact_nxt;
  logic over_r;
  logic over_nxt;
  // Command state: write enable latch, reset arm and the recovery down-counter.
  logic wr_en_r;
  logic wr_en_nxt;
  logic armed_r;
  logic armed_nxt;
  logic [CW-1:0] recov_r;
  logic [CW-1:0] recov_nxt;
  // Volatile lock bits and the other power-on defaults that a soft reset restores.
  logic [NUM_BLOCKS-1:0] lock_r;
  logic [NUM_BLOCKS-1:0] lock_nxt;
  logic susp_r;
  logic susp_nxt;
  logic [7:0] param_r;
  logic [7:0] param_nxt;
  // One-cycle abort strobe and the next protection map.
  logic abort_nxt;
  logic [NUM_BLOCKS-1:0] wp_nxt;

  // Select rising, seen after synchronisation, closes the frame.
  logic frame_end;
  assign frame_end = cs_n_q & ~cs_d_r;

  // Next-state logic for the frame tracker, the command decoder and the protection map.
  always_comb begin
    shift_nxt = shift_r;
    bit_cnt_nxt = bit_cnt_r;
    exact_nxt = exact_r;
    over_nxt = over_r;
    wr_en_nxt = wr_en_r;
    armed_nxt = armed_r;
    recov_nxt = recov_r;
    lock_nxt = lock_r;
    // Suspend is sticky until a soft reset; a new suspend in the reset cycle still sets it.
    susp_nxt = susp_r | suspend_in;
    param_nxt = param_r;
    abort_nxt = 1'b0;
    // The recovery counter runs down on its own; frames ending while it is non-zero are dropped.
    if (recov_r != '0) begin
      recov_nxt = recov_r - CW'(1);
    end
    if (cs_n_q) begin
      bit_cnt_nxt = BIT_CNT_RESET;
      exact_nxt = 1'b0;
      over_nxt = 1'b0;
    end else if (sck_rise) begin
      shift_nxt = {shift_r[6:0], din_q};
      bit_cnt_nxt = bit_cnt_r + 3'h1;
      // A ninth bit or more spoils the frame for good, so a sixteen-bit frame is never taken.
      over_nxt = over_r | exact_r;
      exact_nxt = (bit_cnt_r == 3'h7) && !(exact_r || over_r);
    end
    // A command counts only when select rises right after exactly eight bits.
    if (frame_end && recov_r == '0) begin
      if (exact_r && !over_r) begin
        // Any complete command disarms a pending reset unless it re-arms it.
        armed_nxt = 1'b0;
        // Lock and unlock consume the write enable latch once they are accepted.
        unique case (shift_r)
          OP_WRITE_ENABLE: wr_en_nxt = 1'b1;
          OP_WRITE_DISABLE: wr_en_nxt = 1'b0;
          OP_GLOBAL_LOCK: begin
            if (wr_en_r) begin
              lock_nxt = '1;
              wr_en_nxt = 1'b0;
            end
          end
          OP_GLOBAL_UNLOCK: begin
            if (wr_en_r) begin
              lock_nxt = '0;
              wr_en_nxt = 1'b0;
            end
          end
          OP_RESET_ENABLE: armed_nxt = 1'b1;
          // Soft reset restores the power-on state and opens the recovery window.
          OP_RESET_DEVICE: begin
            if (armed_r) begin
              wr_en_nxt = 1'b0;
              susp_nxt = suspend_in;
              param_nxt = READ_PARAM_RESET;
              lock_nxt = '1;
              abort_nxt = 1'b1;
              recov_nxt = CW'(RECOVERY_COUNT);
            end
          end
          default: ;
        endcase
      // A spoiled frame of nine bits or more still counts as a command for the reset arm.
      end else if (exact_r || over_r) begin
        armed_nxt = 1'b0;
      end
    end
    // Protection follows the lock bits only when per-block protection is selected.
    for (int i = 0; i < NUM_BLOCKS; i++) begin
      wp_nxt[i] = per_block_protect_select ? lock_nxt[i] : range_protect[i];
    end
  end

  // Status mirrors the next values so it lines up with the other registered outputs.
  status_s status_nxt;
  always_comb begin
    status_nxt.write_enable_latch = wr_en_nxt;
    status_nxt.reset_armed = armed_nxt;
    status_nxt.recovering = (recov_nxt != '0);
  end

  // All state except the pin synchronisers and sck_d_r, and every output register, update here, so outputs come straight from flip-flops.
  always_ff @(posedge clk) begin
    if (reset) begin
      cs_d_r <= 1'b1;
      shift_r <= 8'h00;
      bit_cnt_r <= BIT_CNT_RESET;
      exact_r <= 1'b0;
      over_r <= 1'b0;
      wr_en_r <= 1'b0;
      armed_r <= 1'b0;
      recov_r <= '0;
      // Lock bits come up set, but write_protect resets to all clear until the first cycle after reset.
      lock_r <= '1;
      susp_r <= 1'b0;
      param_r <= READ_PARAM_RESET;
      block_lock <= '1;
      write_protect <= '0;
      status <= '0;
      suspend_flag <= 1'b0;
      read_parameter_bits <= READ_PARAM_RESET;
      abort_pulse <= 1'b0;
    end else begin
      cs_d_r <= cs_n_q;
      shift_r <= shift_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      exact_r <= exact_nxt;
      over_r <= over_nxt;
      wr_en_r <= wr_en_nxt;
      armed_r <= armed_nxt;
      recov_r <= recov_nxt;
      lock_r <= lock_nxt;
      susp_r <= susp_nxt;
      param_r <= param_nxt;
      block_lock <= lock_nxt;
      write_protect <= wp_nxt;
      status <= status_nxt;
      suspend_flag <= susp_nxt;
      read_parameter_bits <= param_nxt;
      abort_pulse <= abort_nxt;
    end
  end
endmodule : flash_global_lock_and_soft_reset

// ### verification/lock_reset_checker.sv
// Port assertions for the lock and soft-reset interpreter.
`timescale 1ns/1ps
module lock_reset_checker
  import lock_reset_pkg::*;
#(parameter int NUM_BLOCKS = 16) (
  input wire logic clk,
  input wire logic reset,
  input wire logic per_block_protect_select,
  input wire logic [NUM_BLOCKS-1:0] range_protect,
  input wire logic [NUM_BLOCKS-1:0] block_lock,
  input wire logic [NUM_BLOCKS-1:0] write_protect,
  input wire status_s status,
  input wire logic abort_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_abort_one_cycle: assert property (abort_pulse |=> !abort_pulse) else $error("abort too long");
  a_abort_sets_locks: assert property (abort_pulse |-> ##[0:1] &block_lock) else $error("locks not set");
  a_abort_clears_latch: assert property (abort_pulse |->
    ##[0:1] (!status.write_enable_latch && status.recovering)) else $error("state not reset");
  a_abort_needs_arm: assert property (abort_pulse |->
    $past(status.reset_armed) || $past(status.reset_armed, 2)) else $error("reset not armed");
  a_recovery_ignores: assert property (status.recovering |=> !$rose(status.write_enable_latch))
    else $error("command in recovery");
  a_lock_needs_latch: assert property ($rose(&block_lock) |->
    $past(status.write_enable_latch) || abort_pulse || $past(abort_pulse)) else $error("lock without latch");
  a_unlock_needs_latch: assert property ($fell(|block_lock) |-> $past(status.write_enable_latch))
    else $error("unlock without latch");
  a_protect_select: assert property (!$past(reset) |-> write_protect ==
    ($past(per_block_protect_select) ? block_lock : $past(range_protect))) else $error("bad protect");
  c_abort: cover property (abort_pulse);
  c_unlock: cover property ($fell(|block_lock));
  c_recovery: cover property (status.recovering && !per_block_protect_select);
endmodule : lock_reset_checker
bind flash_global_lock_and_soft_reset lock_reset_checker #(.NUM_BLOCKS(NUM_BLOCKS)) i_lock_reset_checker (
  .clk(clk), .reset(reset), .per_block_protect_select(per_block_protect_select), .range_protect(range_protect),
  .block_lock(block_lock), .write_protect(write_protect), .status(status), .abort_pulse(abort_pulse));

// ### verification/spi_host_model.sv
// Serial host model that shifts the low nbits of a 16-bit word per frame, MSB first.
`timescale 1ns/1ps
module spi_host_model
  import lock_reset_pkg::*;
(
  input wire logic clk,
  output spi_pins_s pins
);
  initial pins = 3'b100;
  task automatic send(input logic [15:0] word, input int nbits);
    pins.cs_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      pins.serial_in = word[i];
      repeat (4) @(negedge clk);
      pins.sck = 1'b1;
      repeat (4) @(negedge clk);
      pins.sck = 1'b0;
    end
    pins.cs_n = 1'b1;
    pins.serial_in = ~pins.serial_in;
    repeat (4) @(negedge clk);
  endtask : send
endmodule : spi_host_model

// ### verification/testbench.sv
// Self-checking bench for the lock and soft-reset interpreter.
`timescale 1ns/1ps
module testbench;
  import lock_reset_pkg::*;
  logic clk = 1'b0, reset = 1'b1, sel = 1'b1, susp = 1'b0, obs = 1'b0, sflag, abort;
  logic [15:0] rng = 16'h0, lock, wp;
  logic [7:0] rp;
  status_s st;
  spi_pins_s pins;
  logic [43:0] q[$];
  int n_mismatch = 0, num_checks = 0, seed = 32'h31bf, frame_bits = 8, n_abort = 0;
  always #5 clk = ~clk;
  spi_host_model i_spi_host_model (.clk(clk), .pins(pins));
  flash_global_lock_and_soft_reset #(.NUM_BLOCKS(16), .RECOVERY_COUNT(100)) i_flash_global_lock_and_soft_reset (
    .clk(clk), .reset(reset), .spi_pins(pins), .per_block_protect_select(sel), .range_protect(rng),
    .internal_busy(1'b0), .suspend_in(susp), .block_lock(lock), .write_protect(wp), .status(st),
    .suspend_flag(sflag), .read_parameter_bits(rp), .abort_pulse(abort));
  function automatic logic [43:0] x(input logic l, input logic [3:0] f);
    return {{16{l}}, f, sel ? {16{l}} : rng, READ_PARAM_RESET};
  endfunction : x
  task automatic cmd(input logic [7:0] op, input logic [3:0] f, input logic l);
    rng = 16'($random(seed));
    sel = ~sel;
    i_spi_host_model.send({op, op}, frame_bits);
    repeat (4) @(negedge clk);
    q.push_back(x(l, f));
    obs = 1'b1;
    @(negedge clk);
    obs = 1'b0;
    $display("opcode %h done", op);
  endtask : cmd
  always @(posedge clk) if (obs) begin
    num_checks++;
    if ({lock, st, sflag, wp, rp} !== q[0]) begin
      n_mismatch++;
      $display("[ERR] outputs exp %h got %h", q[0], {lock, st, sflag, wp, rp});
    end
    void'(q.pop_front());
  end
  always @(posedge clk) if (abort === 1'b1) n_abort++;
  initial begin
    repeat (5) @(negedge clk);
    reset = 1'b0;
    // Reset release stands for power-up; select stays high for the select delay before any frame.
    repeat (SUPPLY_TO_SELECT_DELAY_US * CLK_MHZ) @(negedge clk);
    cmd(OP_GLOBAL_UNLOCK, 4'h0, 1'b1);
    cmd(OP_WRITE_ENABLE, 4'h8, 1'b1);
    cmd(OP_GLOBAL_UNLOCK, 4'h0, 1'b0);
    cmd(OP_GLOBAL_LOCK, 4'h0, 1'b0);
    cmd(OP_WRITE_ENABLE, 4'h8, 1'b0);
    cmd(OP_RESET_ENABLE, 4'hC, 1'b0);
    cmd(OP_WRITE_ENABLE, 4'h8, 1'b0);
    cmd(OP_RESET_DEVICE, 4'h8, 1'b0);
    susp = 1'b1;
    cmd(OP_GLOBAL_LOCK, 4'h1, 1'b1);
    susp = 1'b0;
    cmd(OP_WRITE_ENABLE, 4'h9, 1'b1);
    cmd(OP_GLOBAL_UNLOCK, 4'h1, 1'b0);
    cmd(OP_RESET_ENABLE, 4'h5, 1'b0);
    cmd(OP_RESET_DEVICE, 4'h2, 1'b1);
    cmd(OP_WRITE_ENABLE, 4'h2, 1'b1);
    repeat (100) @(negedge clk);
    cmd(OP_WRITE_ENABLE, 4'h8, 1'b1);
    frame_bits = 16;
    cmd(OP_GLOBAL_UNLOCK, 4'h8, 1'b1);
    frame_bits = 8;
    cmd(OP_WRITE_DISABLE, 4'h0, 1'b1);
    cmd(OP_GLOBAL_UNLOCK, 4'h0, 1'b1);
    num_checks++;
    if (n_abort !== 1) begin
      n_mismatch++;
      $display("[ERR] abort_pulse count exp 1 got %0d", n_abort);
    end
    final_report();
  end
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
endmodule : testbench
